/* File: verilog/lcd_cmd_defs.svh */
// Constants for the liquid crystal driver command decoder.
`ifndef LCD_CMD_DEFS_SVH
`define LCD_CMD_DEFS_SVH
`define CONTRAST_RESET   6'h20
`define BUSY_TIME_NS     50
`define BUSY_CYCLES      ((`BUSY_TIME_NS + 9) / 10)
`define RESET_TIME_NS    100
`define RESET_CYCLES     ((`RESET_TIME_NS + 9) / 10)
`define COL_MAX          8'hff
`define PAGE_MAX         4'h8
`define ST_BUSY_BIT      7
`define ST_DIR_BIT       6
`define ST_OFF_BIT       5
`define ST_RST_BIT       4
`endif

/* File: verilog/lcd_cmd_pkg.sv */
// Types shared by the command decoder modules.
package lcd_cmd_pkg;
   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} cycle_type;
   typedef enum logic [1:0] {ST_RUN, ST_BUSY, ST_SWRESET} phase_type;
endpackage : lcd_cmd_pkg

/* File: verilog/lcd_bus_front.sv */
// Pin synchroniser and bus cycle classifier for 80-style, 68-style and serial hosts.
`timescale 1ns/1ps
module lcd_bus_front (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  mode_68,
   input  wire logic                  serial_sel,
   input  wire logic                  cmd_data_select,
   input  wire logic                  rd_e,
   input  wire logic                  wr_rw,
   input  wire logic                  ser_clk,
   input  wire logic                  ser_data,
   input  wire logic                  chip_sel_n,
   input  wire logic [7:0]            data_in,
   output lcd_cmd_pkg::cycle_type     cycle_ev,
   output logic                       cycle_a0,
   output logic [7:0]                 cycle_byte
);
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] old;
      logic [7:0] d1;
      logic [7:0] d2;
      logic [7:0] shift;
      logic [2:0] cnt;
      lcd_cmd_pkg::cycle_type ev;
      logic       a0;
      logic [7:0] byte_v;
   } state_type;
   state_type st_r;
   state_type st_nxt;
   logic      strobe_on;
   logic      strobe_was;
   logic      rd_sel;

   // Logic reads only the second stage and its one-cycle-delayed copy in old.
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = {cmd_data_select, rd_e, wr_rw, ser_clk, ser_data, chip_sel_n};
      st_nxt.s2 = st_r.s1;
      st_nxt.d1 = data_in;
      st_nxt.d2 = st_r.d1;
      st_nxt.old = st_r.s2;
      st_nxt.ev = lcd_cmd_pkg::BUS_IDLE;
      strobe_on = mode_68 ? st_r.s2[4] : !(st_r.s2[4] && st_r.s2[3]);
      strobe_was = mode_68 ? st_r.old[4] : !(st_r.old[4] && st_r.old[3]);
      rd_sel = mode_68 ? st_r.old[3] : !st_r.old[4];
      if (st_r.s2[0]) begin
         st_nxt.cnt = 3'h0;
      end else if (serial_sel) begin
         if (st_r.s2[2] && !st_r.old[2]) begin
            st_nxt.shift = {st_r.shift[6:0], st_r.s2[1]};
            st_nxt.cnt = st_r.cnt + 3'h1;
            if (st_r.cnt == 3'h7) begin
               st_nxt.ev = lcd_cmd_pkg::BUS_WRITE;
               st_nxt.a0 = st_r.s2[5];
               st_nxt.byte_v = {st_r.shift[6:0], st_r.s2[1]};
            end
         end
      end else if (strobe_was && !strobe_on) begin
         // Data is latched at the trailing edge of the strobe.
         st_nxt.ev = rd_sel ? lcd_cmd_pkg::BUS_READ : lcd_cmd_pkg::BUS_WRITE;
         st_nxt.a0 = st_r.old[5];
         st_nxt.byte_v = st_r.d2;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '{s1: 6'h01, s2: 6'h01, old: 6'h01, ev: lcd_cmd_pkg::BUS_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cycle_ev = st_r.ev;
   assign cycle_a0 = st_r.a0;
   assign cycle_byte = st_r.byte_v;
endmodule : lcd_bus_front

/* File: verilog/lcd_cmd_decoder.sv */
// Command decoder and initial-state logic of the dot-matrix display driver.
// Notes on behaviour
// - Reset pin: display off, normal, power zero, bias 1/9.
// - Reset clears indicator, modify mode, start, column, page.
// - Reset clears ratio, contrast 100000, inversion register, test.
// - Reset command applies only items eleven to twenty.
// - Classify cycles from select and strobes, internal timing.
// - Command 1010111x switches display on or off.
// - Display off drives outputs to positive supply.
// - Command 01xxxxxx sets start line, 65 lines scanned.
// - Command 1011xxxx sets page 0 to 8.
// - Column address from high and low nibble commands.
// - Column increments per access, saturates, page fixed.
// - Status read: busy, direction, off, resetting, zeros.
// - Busy set during operation or reset, refuses commands.
// - Status direction bit inverts direction command bit.
// - Status display bit inverts display on bit.
`timescale 1ns/1ps
`include "lcd_cmd_defs.svh"
module lcd_cmd_decoder (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        init_pin_n,
   input  wire logic        mode_68,
   input  wire logic        serial_sel,
   input  wire logic        cmd_data_select,
   input  wire logic        rd_e,
   input  wire logic        wr_rw,
   input  wire logic        ser_clk,
   input  wire logic        ser_data,
   input  wire logic        chip_sel_n,
   input  wire logic [7:0]  data_in,
   output logic [7:0]       data_out,
   output logic             data_oe_n,
   output logic             display_on,
   output logic             blank_to_vdd,
   output logic             seg_reverse,
   output logic             polarity_rev,
   output logic             all_on,
   output logic [5:0]       start_line,
   output logic [3:0]       page_addr,
   output logic [7:0]       col_addr,
   output logic             com_reverse,
   output logic [2:0]       power_ctrl,
   output logic             bias_1_7,
   output logic [2:0]       ratio,
   output logic [5:0]       contrast,
   output logic [3:0]       line_inv,
   output logic             static_ind,
   output logic             rmw_mode,
   output logic             test_mode,
   output logic             power_save,
   output logic             osc_run,
   output logic             busy,
   output logic             resetting
);
   typedef struct packed {
      logic       rp1;
      logic       rp2;
      lcd_cmd_pkg::phase_type ph;
      logic [3:0] cnt;
      logic [7:0] dout;
      logic       oe_n;
      logic       on;
      logic       segrev;
      logic       polrev;
      logic       allon;
      logic [5:0] line;
      logic [3:0] page;
      logic [7:0] col;
      logic [7:0] rmw_col;
      logic       comrev;
      logic [2:0] pwr;
      logic       bias;
      logic [2:0] ratio;
      logic [5:0] contr;
      logic [3:0] linv;
      logic       ind;
      logic       rmw;
      logic       test;
      logic       psave;
      logic       osc;
      logic       blank;
      logic       bsy;
      logic       rsting;
   } state_type;

   localparam state_type RESET_STATE = '{contr: `CONTRAST_RESET, oe_n: 1'b1, blank: 1'b1,
      ph: lcd_cmd_pkg::ST_RUN, default: '0};

   state_type st_r;
   state_type st_nxt;
   lcd_cmd_pkg::cycle_type ev;
   logic       ev_a0;
   logic [7:0] ev_byte;
   logic       pin_rst;

   function automatic logic [7:0] col_step(input logic [7:0] c);
      col_step = (c == `COL_MAX) ? c : c + 8'h01;
   endfunction : col_step

   lcd_bus_front front (
      .clk             (clk),
      .sys_rst         (sys_rst),
      .mode_68         (mode_68),
      .serial_sel      (serial_sel),
      .cmd_data_select (cmd_data_select),
      .rd_e            (rd_e),
      .wr_rw           (wr_rw),
      .ser_clk         (ser_clk),
      .ser_data        (ser_data),
      .chip_sel_n      (chip_sel_n),
      .data_in         (data_in),
      .cycle_ev        (ev),
      .cycle_a0        (ev_a0),
      .cycle_byte      (ev_byte)
   );

   assign pin_rst = !st_r.rp2;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rp1 = init_pin_n;
      st_nxt.rp2 = st_r.rp1;
      st_nxt.oe_n = 1'b1;
      if (pin_rst) begin
         // Items one to twenty, held for as long as the pin stays low.
         st_nxt = RESET_STATE;
         st_nxt.rp1 = init_pin_n;
         st_nxt.rp2 = st_r.rp1;
         st_nxt.ph = lcd_cmd_pkg::ST_SWRESET;
         st_nxt.cnt = 4'(`RESET_CYCLES);
      end else if (st_r.ph != lcd_cmd_pkg::ST_RUN) begin
         // Writes during busy are refused; status read still answers.
         st_nxt.cnt = st_r.cnt - 4'h1;
         if (st_r.cnt == 4'h1) begin
            st_nxt.ph = lcd_cmd_pkg::ST_RUN;
         end
         if (ev == lcd_cmd_pkg::BUS_READ && !ev_a0) begin
            st_nxt.dout = {1'b1, !st_r.segrev, !st_r.on,
               st_r.ph == lcd_cmd_pkg::ST_SWRESET, 4'h0};
            st_nxt.oe_n = 1'b0;
         end
      end else if (ev == lcd_cmd_pkg::BUS_READ) begin
         st_nxt.oe_n = 1'b0;
         if (!ev_a0) begin
            st_nxt.dout = {1'b0, !st_r.segrev, !st_r.on, 1'b0, 4'h0};
         end else begin
            // Display memory sits outside this block; reads return zero.
            st_nxt.dout = 8'h00;
            if (!st_r.rmw) begin
               st_nxt.col = col_step(st_r.col);
            end
         end
      end else if (ev == lcd_cmd_pkg::BUS_WRITE && ev_a0) begin
         st_nxt.col = col_step(st_r.col);
      end else if (ev == lcd_cmd_pkg::BUS_WRITE) begin
         st_nxt.ph = lcd_cmd_pkg::ST_BUSY;
         st_nxt.cnt = 4'(`BUSY_CYCLES);
         casez (ev_byte)
            8'b1010_111?: st_nxt.on = ev_byte[0];
            8'b01??_????: st_nxt.line = ev_byte[5:0];
            8'b1011_????: begin
               if (ev_byte[3:0] <= `PAGE_MAX) begin
                  st_nxt.page = ev_byte[3:0];
               end
            end
            8'b0001_????: begin
               if (!st_r.rmw) begin
                  st_nxt.col = {ev_byte[3:0], st_r.col[3:0]};
               end
            end
            8'b0000_????: begin
               if (!st_r.rmw) begin
                  st_nxt.col = {st_r.col[7:4], ev_byte[3:0]};
               end
            end
            8'b1010_000?: st_nxt.segrev = ev_byte[0];
            8'b1010_011?: st_nxt.polrev = ev_byte[0];
            8'b1010_010?: st_nxt.allon = ev_byte[0];
            8'b1010_001?: st_nxt.bias = ev_byte[0];
            8'b1110_0000: begin
               st_nxt.rmw = 1'b1;
               st_nxt.rmw_col = st_r.col;
            end
            8'b1110_1110: begin
               st_nxt.rmw = 1'b0;
               st_nxt.col = st_r.rmw_col;
            end
            8'b1110_0010: begin
               // Items eleven to twenty only; display and power keep their state.
               st_nxt.ind = 1'b0;
               st_nxt.rmw = 1'b0;
               st_nxt.line = 6'h00;
               st_nxt.col = 8'h00;
               st_nxt.page = 4'h0;
               st_nxt.comrev = 1'b0;
               st_nxt.ratio = 3'h0;
               st_nxt.contr = `CONTRAST_RESET;
               st_nxt.linv = 4'h0;
               st_nxt.test = 1'b0;
               st_nxt.ph = lcd_cmd_pkg::ST_SWRESET;
               st_nxt.cnt = 4'(`RESET_CYCLES);
            end
            8'b1100_????: st_nxt.comrev = ev_byte[3];
            8'b0010_1???: st_nxt.pwr = ev_byte[2:0];
            8'b0010_0???: st_nxt.ratio = ev_byte[2:0];
            default: begin
               st_nxt.ph = lcd_cmd_pkg::ST_RUN;
               st_nxt.cnt = 4'h0;
            end
         endcase
      end
      // Status levels are registered as well, so no output passes through gates.
      st_nxt.blank = !st_nxt.on;
      st_nxt.bsy = st_nxt.ph != lcd_cmd_pkg::ST_RUN;
      st_nxt.rsting = st_nxt.ph == lcd_cmd_pkg::ST_SWRESET;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= RESET_STATE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign data_out = st_r.dout;
   assign data_oe_n = st_r.oe_n;
   assign display_on = st_r.on;
   assign blank_to_vdd = st_r.blank;
   assign seg_reverse = st_r.segrev;
   assign polarity_rev = st_r.polrev;
   assign all_on = st_r.allon;
   assign start_line = st_r.line;
   assign page_addr = st_r.page;
   assign col_addr = st_r.col;
   assign com_reverse = st_r.comrev;
   assign power_ctrl = st_r.pwr;
   assign bias_1_7 = st_r.bias;
   assign ratio = st_r.ratio;
   assign contrast = st_r.contr;
   assign line_inv = st_r.linv;
   assign static_ind = st_r.ind;
   assign rmw_mode = st_r.rmw;
   assign test_mode = st_r.test;
   assign power_save = st_r.psave;
   assign osc_run = st_r.osc;
   assign busy = st_r.bsy;
   assign resetting = st_r.rsting;

   a_pin_reset: assert property (@(posedge clk) disable iff (sys_rst)
      pin_rst |=> !display_on && power_ctrl == 3'h0 && contrast == 6'h20 && !bias_1_7)
      else $error("pin reset state wrong");
   a_pin_extra: assert property (@(posedge clk) disable iff (sys_rst)
      pin_rst |=> !all_on && !osc_run && !power_save && line_inv == 4'h0)
      else $error("pin reset extra state wrong");
   a_pin_addr: assert property (@(posedge clk) disable iff (sys_rst)
      pin_rst |=> col_addr == 8'h00 && page_addr == 4'h0 && start_line == 6'h00)
      else $error("pin reset addresses wrong");
   a_sw_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      !pin_rst && !busy && ev == lcd_cmd_pkg::BUS_WRITE && !ev_a0 && ev_byte == 8'he2
      |=> $stable(display_on) && $stable(power_ctrl) && resetting && contrast == 6'h20)
      else $error("command reset wrong");
   a_disp_cmd: assert property (@(posedge clk) disable iff (sys_rst)
      !pin_rst && !busy && ev == lcd_cmd_pkg::BUS_WRITE && !ev_a0 && ev_byte[7:1] == 7'h57
      |=> display_on == $past(ev_byte[0]))
      else $error("display command ignored");
   a_blank: assert property (@(posedge clk) disable iff (sys_rst)
      blank_to_vdd == !display_on) else $error("blank mismatch");
   a_col_sat: assert property (@(posedge clk) disable iff (sys_rst)
      !pin_rst && $past(col_addr) == 8'hff && !busy && !$past(busy) |-> col_addr != 8'h00 ||
      $past(ev) != lcd_cmd_pkg::BUS_WRITE) else $error("column wrapped");
   a_busy_end: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(busy) && !pin_rst |-> ##[1:12] !busy || pin_rst)
      else $error("busy stuck");
   a_status: assert property (@(posedge clk) disable iff (sys_rst)
      !pin_rst && !busy && ev == lcd_cmd_pkg::BUS_READ && !ev_a0
      |=> data_out == {1'b0, !$past(seg_reverse), !$past(display_on), 5'h00})
      else $error("status byte wrong");
   c_write: cover property (@(posedge clk) ev == lcd_cmd_pkg::BUS_WRITE && !ev_a0);
   c_status: cover property (@(posedge clk) !data_oe_n);
   c_swreset: cover property (@(posedge clk) resetting && !pin_rst);
endmodule : lcd_cmd_decoder

/* File: sim/lcd_host_model.sv */
// Host processor model driving the parallel and serial bus pins of the decoder.
`timescale 1ns/1ps
module lcd_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe_n,
   output logic            init_pin_n,
   output logic            mode_68,
   output logic            serial_sel,
   output logic            cmd_data_select,
   output logic            rd_e,
   output logic            wr_rw,
   output logic            ser_clk,
   output logic            ser_data,
   output logic            chip_sel_n,
   output logic [7:0]      data_in
);
   // Every pin holds a defined level from time zero, so no input floats.
   initial begin
      init_pin_n      = 1'b1;
      mode_68         = 1'b0;
      serial_sel      = 1'b0;
      cmd_data_select = 1'b0;
      rd_e            = 1'b1;
      wr_rw           = 1'b1;
      ser_clk         = 1'b0;
      ser_data        = 1'b0;
      chip_sel_n      = 1'b1;
      data_in         = 8'h00;
   end

   task automatic set_reset(input logic level);
      @(negedge clk);
      init_pin_n = level;
   endtask : set_reset

   task automatic set_mode(input logic m68, input logic ser);
      @(negedge clk);
      mode_68    = m68;
      serial_sel = ser;
      rd_e       = ~m68;
      wr_rw      = 1'b1;
   endtask : set_mode

   // One parallel cycle; a short gap lets the next strobe land while busy.
   task automatic par(input logic a0, input logic rd, input logic [7:0] b, input int low,
                      input int gap, output logic [7:0] rdata);
      rdata = 'x;
      @(negedge clk);
      cmd_data_select = a0;
      chip_sel_n      = 1'b0;
      data_in         = b;
      if (mode_68) begin
         wr_rw = rd;
         rd_e  = 1'b1;
      end else if (rd) begin
         rd_e = 1'b0;
      end else begin
         wr_rw = 1'b0;
      end
      repeat (low) @(negedge clk);
      // The select level must outlive the enable edge, so it is left alone here.
      if (mode_68) begin
         rd_e = 1'b0;
      end else begin
         rd_e  = 1'b1;
         wr_rw = 1'b1;
      end
      for (int i = 0; i < gap; i++) begin
         @(negedge clk);
         if (data_oe_n === 1'b0) begin
            rdata = data_out;
         end
         if (i == 3) begin
            chip_sel_n = 1'b1;
            data_in    = ~b;
         end
      end
   endtask : par

   // The serial clock stands still outside the frame.
   task automatic ser_byte(input logic a0, input logic [7:0] b);
      @(negedge clk);
      cmd_data_select = a0;
      chip_sel_n      = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         ser_data = b[i];
         repeat (2) @(negedge clk);
         ser_clk = 1'b1;
         repeat (2) @(negedge clk);
         ser_clk = 1'b0;
      end
      repeat (14) @(negedge clk);
      chip_sel_n = 1'b1;
      ser_data   = ~b[0];
   endtask : ser_byte
endmodule : lcd_host_model

/* File: sim/testbench.sv */
// Self-checking bench for the display driver command decoder.
`timescale 1ns/1ps
module testbench;
   logic       clk;
   logic       sys_rst;
   logic       init_pin_n, mode_68, serial_sel, cmd_data_select, rd_e, wr_rw;
   logic       ser_clk, ser_data, chip_sel_n, data_oe_n, display_on, blank_to_vdd;
   logic       seg_reverse, polarity_rev, all_on, com_reverse, bias_1_7, static_ind;
   logic       rmw_mode, test_mode, power_save, osc_run, busy, resetting;
   logic [7:0] data_in, data_out, col_addr, st;
   logic [5:0] start_line, contrast;
   logic [3:0] page_addr, line_inv;
   logic [2:0] power_ctrl, ratio;
   int         fail_count;
   int         tests_run;

   lcd_host_model host (
      .clk(clk), .data_out(data_out), .data_oe_n(data_oe_n), .init_pin_n(init_pin_n),
      .mode_68(mode_68), .serial_sel(serial_sel), .cmd_data_select(cmd_data_select),
      .rd_e(rd_e), .wr_rw(wr_rw), .ser_clk(ser_clk), .ser_data(ser_data),
      .chip_sel_n(chip_sel_n), .data_in(data_in));

   lcd_cmd_decoder u_lcd_cmd_decoder (
      .clk(clk), .sys_rst(sys_rst), .init_pin_n(init_pin_n), .mode_68(mode_68),
      .serial_sel(serial_sel), .cmd_data_select(cmd_data_select), .rd_e(rd_e),
      .wr_rw(wr_rw), .ser_clk(ser_clk), .ser_data(ser_data), .chip_sel_n(chip_sel_n),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .display_on(display_on), .blank_to_vdd(blank_to_vdd), .seg_reverse(seg_reverse),
      .polarity_rev(polarity_rev), .all_on(all_on), .start_line(start_line),
      .page_addr(page_addr), .col_addr(col_addr), .com_reverse(com_reverse),
      .power_ctrl(power_ctrl), .bias_1_7(bias_1_7), .ratio(ratio), .contrast(contrast),
      .line_inv(line_inv), .static_ind(static_ind), .rmw_mode(rmw_mode),
      .test_mode(test_mode), .power_save(power_save), .osc_run(osc_run), .busy(busy),
      .resetting(resetting));

   initial begin
      clk = 1'b0;
   end

   always begin
      #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   task automatic cmd(input logic [7:0] b);
      host.par(1'b0, 1'b0, b, 3, 14, st);
   endtask : cmd

   task automatic stat();
      host.par(1'b0, 1'b1, 8'h00, 3, 14, st);
   endtask : stat

   // Pin reset, then every item of the initial state is compared while held low.
   task automatic pin_reset();
      host.set_reset(1'b0);
      repeat (6) @(negedge clk);
      check({display_on, blank_to_vdd, seg_reverse, polarity_rev, power_ctrl, bias_1_7},
            8'h40);
      check({line_inv, power_save, all_on, osc_run, static_ind}, 8'h00);
      check({static_ind, rmw_mode, start_line, col_addr, page_addr, com_reverse}, 21'h0);
      check({ratio, contrast, line_inv, test_mode}, 14'h0400);
      host.set_reset(1'b1);
      repeat (3) @(negedge clk);
      check({resetting, busy}, 2'h3);
      repeat (20) @(negedge clk);
   endtask : pin_reset

   initial begin
      fail_count = 0;
      tests_run  = 0;
      sys_rst    = 1'b1;
      repeat (5) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      pin_reset();
      stat();
      check(st, 8'h60);
      cmd(8'haf);
      check({display_on, blank_to_vdd}, 2'h2);
      stat();
      check(st, 8'h40);
      cmd(8'ha1);
      stat();
      check(st, 8'h00);
      cmd(8'h7f);
      check(start_line, 6'h3f);
      cmd(8'h55);
      check(start_line, 6'h15);
      cmd(8'hb8);
      check(page_addr, 4'h8);
      cmd(8'hb9);
      check(page_addr, 4'h8);
      cmd(8'hf0);
      check({page_addr, start_line}, 10'h215);
      cmd(8'h1f);
      cmd(8'h0e);
      check(col_addr, 8'hfe);
      for (int k = 0; k < 2; k++) begin
         host.par(1'b1, 1'b0, 8'h5a, 3, 14, st);
         check(col_addr, 8'hff);
      end
      check(page_addr, 4'h8);
      // Second write lands inside the busy window and must be dropped.
      host.par(1'b0, 1'b0, 8'hb5, 2, 1, st);
      host.par(1'b0, 1'b0, 8'hb6, 2, 14, st);
      check(page_addr, 4'h5);
      cmd(8'h10);
      cmd(8'h03);
      check(col_addr, 8'h03);
      cmd(8'he0);
      host.par(1'b1, 1'b1, 8'h00, 3, 14, st);
      check({rmw_mode, col_addr}, 9'h103);
      host.par(1'b1, 1'b0, 8'h5a, 3, 14, st);
      check(col_addr, 8'h04);
      cmd(8'hee);
      check({rmw_mode, col_addr}, 9'h003);
      host.par(1'b1, 1'b1, 8'h00, 3, 14, st);
      check({st, col_addr}, 16'h0004);
      host.set_mode(1'b1, 1'b0);
      cmd(8'hb1);
      check(page_addr, 4'h1);
      stat();
      check(st, 8'h00);
      host.set_mode(1'b0, 1'b1);
      host.ser_byte(1'b0, 8'hb2);
      check(page_addr, 4'h2);
      host.set_mode(1'b0, 1'b0);
      cmd(8'ha7);
      cmd(8'ha5);
      cmd(8'ha3);
      cmd(8'hc8);
      cmd(8'h2f);
      cmd(8'h25);
      check({polarity_rev, all_on, bias_1_7, com_reverse, power_ctrl, ratio}, 10'h3fd);
      host.par(1'b0, 1'b0, 8'he2, 3, 1, st);
      host.par(1'b0, 1'b1, 8'h00, 2, 14, st);
      check(st, 8'h90);
      repeat (10) @(negedge clk);
      check({display_on, seg_reverse, polarity_rev, all_on, bias_1_7, power_ctrl, com_reverse,
             ratio}, 12'hff0);
      check({start_line, col_addr, page_addr}, 18'h0);
      check({contrast, test_mode, static_ind, rmw_mode}, 9'h100);
      pin_reset();
      results();
   end

   // The whole sequence needs under a tenth of this span.
   initial begin
      #200_000;
      fail_count++;
      results();
   end
endmodule : testbench
